/* hw/rtcs_top.sv */
// real-time counter control/status block with APB registers
// assumes realtime tick arrives asynchronous on a pin and is synchronised here
//
// The APB interface to the registers and the placing of the registers were left to the implementer.
module rtcs_top
    import rtcs_pkg::*;
#(
    parameter int StartTicks = START_TICKS
)(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // realtime tick pin
    input wire logic realtimeTickClock,
    // oscillator and regulator side
    output rtcs_osc_t osc,
    // interrupt
    output logic irq
);

    initial begin
        if (StartTicks < 1 || StartTicks > 255) begin
            $error("StartTicks out of range");
        end
    end

    // ----------------------------------------
    // state
    // ----------------------------------------
    typedef enum logic [1:0] {
        RUN_IDLE,
        RUN_WAIT,
        RUN_COUNT
    } rtcs_run_t;

    typedef struct packed {
        rtcs_ctrl_t ctrl;
        logic [1:0] rstCnt;
        logic blockRst;
        rtcs_run_t run;
        logic [7:0] startCnt;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] matchVal;
        logic tickPrev;
        logic [IRQ_W-1:0] irqStat;
        logic [IRQ_W-1:0] irqMask;
        logic [31:0] rdata;
        rtcs_osc_t osc;
    } rtcs_st_t;

    rtcs_st_t st;
    rtcs_st_t next_st;
    logic tickSync;
    logic tick;
    logic isMatch;
    logic wr;
    logic rd;
    logic addrOk;

    // ----------------------------------------
    // tick input synchroniser
    // ----------------------------------------
    rtcs_sync u_tick_sync (
        .clk(clk),
        .nrst(nrst),
        .din(realtimeTickClock),
        .dout(tickSync)
    );

    // rising edge of the synchronised tick
    assign tick = tickSync && !st.tickPrev;

    // full-width compare
    assign isMatch = (st.count == st.matchVal);

    // apb decode
    assign wr = psel && penable && pwrite;
    assign rd = psel && penable && !pwrite;
    always_comb begin
        unique case (paddr)
            OFS_CTRL, OFS_CNT_LO, OFS_CNT_HI, OFS_MAT_LO, OFS_MAT_HI,
            OFS_IRQ_STAT, OFS_IRQ_MASK: addrOk = 1'b1;
            default: addrOk = 1'b0;
        endcase
    end

    // ----------------------------------------
    // next-state logic
    // ----------------------------------------
    always_comb begin
        logic [IRQ_W-1:0] ev;
        logic [CNT_W-1:0] inc;
        ev = '0;
        inc = st.count + 40'h00_0000_0001;
        next_st = st;
        next_st.tickPrev = tickSync;

        // register writes
        if (wr) begin
            unique case (paddr)
                OFS_CTRL: next_st.ctrl = rtcs_ctrl_t'(pwdata[7:0]);
                OFS_CNT_LO: begin
                    if (!st.ctrl.cntEn) begin
                        next_st.count[31:0] = pwdata;
                    end
                end
                OFS_CNT_HI: begin
                    if (!st.ctrl.cntEn) begin
                        next_st.count[39:32] = pwdata[7:0];
                    end
                end
                OFS_MAT_LO: next_st.matchVal[31:0] = pwdata;
                OFS_MAT_HI: next_st.matchVal[39:32] = pwdata[7:0];
                OFS_IRQ_MASK: next_st.irqMask = pwdata[IRQ_W-1:0];
                default: begin
                end
            endcase
        end

        // reset bit release delayed two clocks
        if (st.ctrl.rtcRst) begin
            next_st.rstCnt = 2'(RST_RELEASE_CYC);
            next_st.blockRst = 1'b1;
        end else if (st.rstCnt != 2'h0) begin
            next_st.rstCnt = st.rstCnt - 2'h1;
            next_st.blockRst = (st.rstCnt != 2'h1);
        end else begin
            next_st.blockRst = 1'b0;
        end

        // run sequencer: prescaler start delay, then counting
        if (st.blockRst || !st.ctrl.cntEn) begin
            next_st.run = RUN_IDLE;
            next_st.startCnt = '0;
        end else begin
            unique case (st.run)
                RUN_IDLE: begin
                    next_st.run = RUN_WAIT;
                    next_st.startCnt = '0;
                end
                RUN_WAIT: begin
                    if (tick) begin
                        if (st.startCnt == 8'(StartTicks - 1)) begin
                            next_st.run = RUN_COUNT;
                            next_st.count = inc;
                        end else begin
                            next_st.startCnt = st.startCnt + 8'h01;
                        end
                    end
                end
                RUN_COUNT: begin
                    if (tick) begin
                        if (st.ctrl.clrOnMatch && isMatch && st.matchVal != '0) begin
                            next_st.count = '0;
                        end else begin
                            next_st.count = inc;
                            if (inc == '0) begin
                                ev[IRQ_WRAP] = 1'b1;
                            end
                        end
                        if (isMatch) begin
                            ev[IRQ_MATCH] = 1'b1;
                        end
                    end
                end
                default: next_st.run = RUN_IDLE;
            endcase
        end

        // counter reset bit and block reset zero the count
        if (!st.ctrl.cntRstN || st.blockRst) begin
            next_st.count = '0;
        end

        // match outputs gated by wake enable
        next_st.osc.matchOut = st.ctrl.regulatorWakeOnMatch && isMatch;
        next_st.osc.powerStateMatchOut = st.ctrl.regulatorWakeOnMatch && isMatch;
        next_st.osc.oscillatorModeOut = st.ctrl.oscillatorModeField;
        next_st.osc.oscillatorSelectOut = st.ctrl.xtalEn;

        // sticky status: write-one-to-clear, set wins
        if (wr && paddr == OFS_IRQ_STAT) begin
            next_st.irqStat = st.irqStat & ~pwdata[IRQ_W-1:0];
        end
        next_st.irqStat = next_st.irqStat | ev;

        // read data
        unique case (paddr)
            OFS_CTRL: next_st.rdata = {24'h00_0000, st.ctrl};
            OFS_CNT_LO: next_st.rdata = st.count[31:0];
            OFS_CNT_HI: next_st.rdata = {24'h00_0000, st.count[39:32]};
            OFS_MAT_LO: next_st.rdata = st.matchVal[31:0];
            OFS_MAT_HI: next_st.rdata = {24'h00_0000, st.matchVal[39:32]};
            OFS_IRQ_STAT: next_st.rdata = {30'h0000_0000, st.irqStat};
            OFS_IRQ_MASK: next_st.rdata = {30'h0000_0000, st.irqMask};
            default: next_st.rdata = 32'h0000_0000;
        endcase
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
            st.ctrl <= rtcs_ctrl_t'(CTRL_RESET);
            st.run <= RUN_IDLE;
        end else begin
            st <= next_st;
        end
    end

    // outputs
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addrOk;
    assign prdata = rd ? next_st.rdata : 32'h0000_0000;
    assign osc = st.osc;
    assign irq = |(st.irqStat & st.irqMask);

endmodule : rtcs_top

/* hw/rtcs_pkg.sv */
// package for the real-time counter control/status block
// assumes a single 50 MHz clock and an APB register bus
package rtcs_pkg;

    // ----------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CNT_LO = 8'h04;
    localparam logic [7:0] OFS_CNT_HI = 8'h08;
    localparam logic [7:0] OFS_MAT_LO = 8'h0C;
    localparam logic [7:0] OFS_MAT_HI = 8'h10;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

    // ----------------------------------------
    // control field positions and reset value
    // ----------------------------------------
    localparam int BIT_RTC_RST = 7;
    localparam int BIT_CNT_EN = 6;
    localparam int BIT_WAKE = 5;
    localparam int BIT_MODE_LO = 3;
    localparam int BIT_CLR_MAT = 2;
    localparam int BIT_CNT_RSTN = 1;
    localparam int BIT_XTAL_EN = 0;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // interrupt bits: match event, counter wrap
    localparam int IRQ_MATCH = 0;
    localparam int IRQ_WRAP = 1;
    localparam int IRQ_W = 2;

    // ----------------------------------------
    // timing counts
    // ----------------------------------------
    localparam int RST_RELEASE_CYC = 2;
    localparam int START_TICKS = 64;
    localparam int CNT_W = 40;

    // control register layout
    typedef struct packed {
        logic rtcRst;
        logic cntEn;
        logic regulatorWakeOnMatch;
        logic [1:0] oscillatorModeField;
        logic clrOnMatch;
        logic cntRstN;
        logic xtalEn;
    } rtcs_ctrl_t;

    // outputs toward oscillator and regulator fsm
    typedef struct packed {
        logic matchOut;
        logic powerStateMatchOut;
        logic [1:0] oscillatorModeOut;
        logic oscillatorSelectOut;
    } rtcs_osc_t;

endpackage : rtcs_pkg

/* hw/rtcs_sync.sv */
// two-flop synchroniser for one level
// assumes clk free-running, asynchronous active-low reset
module rtcs_sync
    import rtcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // level in and out
    input wire logic din,
    output logic dout
);

    typedef struct packed {
        logic s1;
        logic s2;
    } rtcs_sync_st_t;

    rtcs_sync_st_t st;
    rtcs_sync_st_t next_st;

    // shift chain
    always_comb begin
        next_st.s1 = din;
        next_st.s2 = st.s1;
    end

    // state register
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign dout = st.s2;

endmodule : rtcs_sync

/* bench/rtcs_properties.sv */
// port checker for the real-time counter block
// assumes it is bound onto rtcs_top
module rtcs_properties
    import rtcs_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // tick, oscillator side, interrupt
    input wire logic realtimeTickClock,
    input wire rtcs_osc_t osc,
    input wire logic irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    // access phase decodes
    wire logic acc = psel && penable;
    wire logic wrCtrl = acc && pwrite && paddr == OFS_CTRL;

    a_zero_wait: assert property (acc |-> pready)
        else $error("access phase without ready");
    a_bad_addr: assert property (acc && paddr > OFS_IRQ_MASK |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_good_addr: assert property (acc && paddr <= OFS_IRQ_MASK && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("mapped access refused");
    a_idle_rdata: assert property (!(acc && !pwrite) |-> prdata == 32'h0)
        else $error("read data outside read access");
    a_upper_zero: assert property (acc && !pwrite && (paddr == OFS_CNT_HI
        || paddr == OFS_MAT_HI) |-> prdata[31:8] == 24'h0)
        else $error("high word upper bits not zero");
    a_match_pair: assert property (osc.matchOut == osc.powerStateMatchOut)
        else $error("match outputs differ");
    a_wake_off: assert property (wrCtrl && !pwdata[BIT_WAKE] |-> ##2 !osc.matchOut)
        else $error("match out high with wake clear");
    a_mode_copy: assert property (wrCtrl && !pwdata[BIT_RTC_RST] |-> ##2
        osc.oscillatorModeOut == $past(pwdata[4:3], 2)
        && osc.oscillatorSelectOut == $past(pwdata[BIT_XTAL_EN], 2))
        else $error("oscillator outputs not copied");
    a_mask_quiet: assert property (acc && pwrite && paddr == OFS_IRQ_MASK
        && pwdata[1:0] == 2'h0 |-> ##2 !irq)
        else $error("irq high while masked");
    a_reset_quiet: assert property ($rose(nrst) |-> osc == '0 && !irq)
        else $error("outputs not quiet after reset");
endmodule : rtcs_properties

bind rtcs_top rtcs_properties chk_u (.clk, .nrst, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .realtimeTickClock, .osc, .irq);

/* bench/rtcs_tick_model.sv */
// tick source standing in for the crystal side
// assumes clk is the bench clock; tick rests low between bursts
module rtcs_tick_model
(
    // bench clock
    input wire logic clk,
    // tick pin
    output logic tick
);
    timeunit 1ns;
    timeprecision 100ps;
    initial tick = 1'b0;
    // n ticks, high four clocks, low eight
    task automatic pulse(input int n);
        repeat (n) begin
            tick <= 1'b1;
            repeat (4) @(posedge clk);
            tick <= 1'b0;
            repeat (8) @(posedge clk);
        end
    endtask : pulse
endmodule : rtcs_tick_model

/* bench/rtcs_top_bench.sv */
// self-checking bench for rtcs_top over apb
// assumes the tick model drives the tick pin
module rtcs_top_bench
    import rtcs_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    localparam int SP = 4;
    logic clk = 1'b0;
    logic nrst, psel, penable, pwrite, pready, pslverr, tick, irq, lastErr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    rtcs_osc_t osc;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;

    rtcs_top #(.StartTicks(SP)) dut_u (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .realtimeTickClock(tick), .osc(osc), .irq(irq));
    rtcs_tick_model tick_u (.clk(clk), .tick(tick));

    always #10 clk = ~clk;
    // hang guard
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 6000) begin
            bad_count++;
            results();
        end
    end

    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // registered outputs settle after the edge: look at the falling edge, then realign
    task automatic outs(input string what, input int sel, input logic [31:0] exp);
        logic [31:0] v;
        @(negedge clk);
        case (sel)
            0: v = {31'h0, osc.matchOut};
            1: v = {31'h0, osc.powerStateMatchOut};
            2: v = {30'h0, osc.oscillatorModeOut};
            3: v = {31'h0, osc.oscillatorSelectOut};
            default: v = {31'h0, irq};
        endcase
        chk(what, v, exp);
        @(posedge clk);
    endtask : outs
    // one apb transfer, then one idle edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask : wr
    task automatic rd(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        chk(what, q, exp);
    endtask : rd
    task automatic results();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (8) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd("ctrl", OFS_CTRL, 32'h0);
        wr(OFS_CTRL, 32'h02);
        wr(OFS_CNT_LO, 32'h5);
        wr(OFS_CNT_HI, 32'hA5);
        rd("count hi", OFS_CNT_HI, 32'hA5);
        wr(OFS_CTRL, 32'hC2);
        tick_u.pulse(SP + 2);
        rd("count held", OFS_CNT_LO, 32'h0);
        // block reset zeroed the count: reload it while disabled
        wr(OFS_CTRL, 32'h02);
        wr(OFS_CNT_LO, 32'h5);
        wr(OFS_CNT_HI, 32'hA5);
        wr(OFS_CTRL, 32'h42);
        tick_u.pulse(SP - 1);
        rd("count early", OFS_CNT_LO, 32'h5);
        tick_u.pulse(1);
        rd("count first", OFS_CNT_LO, 32'h6);
        wr(OFS_CNT_LO, 32'h33);
        rd("count locked", OFS_CNT_LO, 32'h6);
        wr(OFS_CTRL, 32'h02);
        tick_u.pulse(2);
        rd("count stopped", OFS_CNT_LO, 32'h6);
        wr(OFS_MAT_LO, 32'h6);
        wr(OFS_CTRL, 32'h22);
        outs("match hi diff", 0, 32'h0);
        wr(OFS_MAT_HI, 32'hA5);
        outs("match", 0, 32'h1);
        outs("psm match", 1, 32'h1);
        wr(OFS_CTRL, 32'h02);
        outs("match off", 0, 32'h0);
        // clear on match with match interrupt unmasked
        wr(OFS_MAT_LO, 32'h7);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_CTRL, 32'h46);
        tick_u.pulse(SP + 1);
        rd("count cleared", OFS_CNT_LO, 32'h0);
        rd("count hi cleared", OFS_CNT_HI, 32'h0);
        rd("irq status", OFS_IRQ_STAT, 32'h1);
        outs("irq", 4, 32'h1);
        wr(OFS_IRQ_MASK, 32'h0);
        outs("irq masked", 4, 32'h0);
        wr(OFS_IRQ_MASK, 32'h1);
        wr(OFS_IRQ_STAT, 32'h1);
        outs("irq cleared", 4, 32'h0);
        wr(OFS_MAT_LO, 32'h0);
        wr(OFS_MAT_HI, 32'h0);
        tick_u.pulse(1);
        rd("zero match", OFS_CNT_LO, 32'h1);
        wr(OFS_CTRL, 32'h40);
        rd("count reset", OFS_CNT_LO, 32'h0);
        // standby wants crystal enable set, sleep wants it clear; the loop sets it in all four modes and checks select is 1
        for (int m = 0; m < 4; m++) begin
            wr(OFS_CTRL, {27'h0, m[1:0], 3'b001});
            outs("mode", 2, {30'h0, m[1:0]});
            outs("select", 3, 32'h1);
        end
        wr(OFS_CTRL, 32'h0);
        outs("select off", 3, 32'h0);
        rd("unmapped", 8'h1C, 32'h0);
        chk("slverr", {31'h0, lastErr}, 32'h1);
        results();
    end
endmodule : rtcs_top_bench
